// file: dso_pkg.sv
// Package of constants for the drive status output selector
package dso_pkg;

    // ************************************************************
    // Sizes
    // ************************************************************
    localparam int N_TERM  = 7;                  // Configurable output terminals
    localparam int CODE_W  = 16;                 // Function code width
    localparam int VAL_W   = 16;                 // Frequency, current and limit width
    localparam int PCT_W   = 7;                  // Percentage input width
    localparam int COND_N  = 17;                 // Condition slots 0..16
    localparam int EVT_N   = 19;                 // Conditions plus two trips
    localparam int CFG_N   = 12;                 // Threshold registers

    // ************************************************************
    // Function code ranges and condition slots
    // ************************************************************
    localparam logic [CODE_W-1:0] POS_MAX  = 16'h0063;  // 99
    localparam logic [CODE_W-1:0] NEG_BASE = 16'h0064;  // 100
    localparam logic [CODE_W-1:0] NEG_MAX  = 16'h00c7;  // 199
    localparam logic [COND_N-1:0] COND_VALID = 17'h1fdff; // Slot 9 undefined
    localparam int C_RUN = 0, C_SPEED = 1, C_PLOSS = 2, C_STALL = 3;
    localparam int C_FL1 = 4, C_FL2 = 5, C_FL3 = 6, C_RBP = 7, C_THP = 8;
    localparam int C_PANEL = 10, C_READY = 11, C_CUR = 12, C_LOW = 13;
    localparam int C_PIDLO = 14, C_PIDHI = 15, C_PIDFWD = 16;
    localparam int E_TRIP_INV = 17, E_TRIP_MOT = 18;

    // ************************************************************
    // Thresholds and modes
    // ************************************************************
    localparam logic [PCT_W-1:0] PREALARM_PCT = 7'h55;   // 85 percent
    localparam logic [PCT_W-1:0] TRIP_PCT     = 7'h64;   // 100 percent
    localparam logic [1:0]       MODE_PANEL   = 2'h1;    // Panel operation mode code
    localparam int CLK_HZ      = 10_000_000;
    localparam int READY_US    = 10;                     // Power-up processing time
    localparam int READY_CYC   = (READY_US * (CLK_HZ / 1_000_000) < 1) ? 1 :
                                 READY_US * (CLK_HZ / 1_000_000);

    // ************************************************************
    // Register map (byte addresses)
    // ************************************************************
    localparam logic [7:0] A_FCODE  = 8'h00;   // Terminal codes, 0x00..0x18
    localparam logic [7:0] A_CFG    = 8'h20;   // Threshold block, 0x20..0x4c
    localparam logic [7:0] A_COND   = 8'h50;   // Live condition vector, read only
    localparam logic [7:0] A_TERM   = 8'h54;   // Terminal levels, read only
    localparam logic [7:0] A_STATUS = 8'h58;   // Sticky events, write one to clear
    localparam logic [7:0] A_MASK   = 8'h5c;   // Interrupt mask

    // Index of each threshold inside the threshold block
    localparam int K_START = 0, K_LVL1 = 1, K_LVL1R = 2, K_LVL2 = 3, K_LVL3 = 4;
    localparam int K_BAND = 5, K_CURTHR = 6, K_CURTIME = 7, K_LOWTHR = 8;
    localparam int K_LOWTIME = 9, K_PIDLO = 10, K_PIDHI = 11;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [N_TERM-1:0][CODE_W-1:0] FCODE_RST =
        {16'h270f, 16'h0063, 16'h0004, 16'h0003, 16'h0002, 16'h0001, 16'h0000};
    localparam logic [VAL_W-1:0] CFG_RST  = 16'h0000;
    localparam logic [EVT_N-1:0] MASK_RST = 19'h00000;

endpackage

// file: dso_selector.sv
// Drive status output selector with Avalon-MM register slave
//
// Our own choices: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
module dso_selector
    import dso_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic [7:0]        avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic      [31:0]       avs_readdata,
    output logic                   avs_waitrequest,
    output logic                   irq,
    input  wire logic              drive_running,
    input  wire logic [VAL_W-1:0]  output_freq,
    input  wire logic [VAL_W-1:0]  set_freq,
    input  wire logic              reverse_dir,
    input  wire logic              supply_interrupt,
    input  wire logic              undervoltage,
    input  wire logic              stall_prevention_active,
    input  wire logic [PCT_W-1:0]  regen_duty_pct,
    input  wire logic [PCT_W-1:0]  thermal_inv_pct,
    input  wire logic [PCT_W-1:0]  thermal_mot_pct,
    input  wire logic [1:0]        operation_mode,
    input  wire logic              start_permitted,
    input  wire logic [VAL_W-1:0]  output_current,
    input  wire logic [VAL_W-1:0]  monitored_power,
    input  wire logic [VAL_W-1:0]  pid_feedback,
    input  wire logic              pid_forward_out,
    output logic      [N_TERM-1:0] terminal_out,
    output logic                   thermal_trip_inverter,
    output logic                   thermal_trip_motor
);

    // ************************************************************
    // Register storage
    // ************************************************************
    logic [CODE_W-1:0] fcode_q [N_TERM];     // Function code per terminal
    logic [VAL_W-1:0]  cfg_q   [CFG_N];      // Thresholds and times
    logic [EVT_N-1:0]  status_q;             // Sticky event bits
    logic [EVT_N-1:0]  mask_q;               // Interrupt enables
    logic              ack_q;                // Bus answer phase
    logic [31:0]       rdata_q;              // Registered read data
    logic [COND_N-1:0] cond_q;               // Registered conditions
    logic [COND_N-1:0] cond_d;               // Next conditions
    logic [N_TERM-1:0] term_q;               // Registered terminal levels
    logic [N_TERM-1:0] term_d;               // Next terminal levels
    logic              trip_inv_q;           // Inverter thermal trip
    logic              trip_mot_q;           // Motor thermal trip
    logic [VAL_W-1:0]  cur_cnt_q;            // Cycles above current threshold
    logic [VAL_W-1:0]  low_cnt_q;            // Cycles below low threshold
    logic [15:0]       rdy_cnt_q;            // Power-up processing counter
    logic              rdy_done_q;           // Power-up processing complete

    // ************************************************************
    // Bus decode
    // ************************************************************
    wire        req      = avs_read | avs_write;          // Any request pending
    wire        wr_fire  = avs_write & ack_q;             // Write takes effect
    wire [5:0]  widx     = avs_address[7:2];              // Word index
    wire [5:0]  fc_base  = A_FCODE[7:2];
    wire [5:0]  cfg_base = A_CFG[7:2];
    wire        hit_fc   = (widx >= fc_base) && (widx < fc_base + 6'(N_TERM));
    wire        hit_cfg  = (widx >= cfg_base) && (widx < cfg_base + 6'(CFG_N));
    wire [5:0]  fc_sel   = widx - fc_base;                // Terminal selected
    wire [5:0]  cfg_sel  = widx - cfg_base;               // Threshold selected
    wire [31:0] be_mask  = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                            {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    wire        wr_stat  = wr_fire && (avs_address == A_STATUS);
    wire        wr_mask  = wr_fire && (avs_address == A_MASK);
    wire [EVT_N-1:0] w1c = wr_stat ? (avs_writedata[EVT_N-1:0] & be_mask[EVT_N-1:0])
                                   : '0;

    // Merge enabled byte lanes of write data into a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old_v);
        merge16 = (old_v & ~be_mask[15:0]) | (avs_writedata[15:0] & be_mask[15:0]);
    endfunction

    // One wait state on every access; answer when ack_q is high
    assign avs_waitrequest = req & ~ack_q;
    assign avs_readdata    = rdata_q;

    // ************************************************************
    // Read data selection
    // ************************************************************
    logic [31:0] rsel;
    always_comb begin
        rsel = 32'h0000_0000;                              // Unmapped reads zero
        if (hit_fc) begin
            rsel = {16'h0000, fcode_q[fc_sel[2:0]]};
        end else if (hit_cfg) begin
            rsel = {16'h0000, cfg_q[cfg_sel[3:0]]};
        end else begin
            unique case (avs_address)
                A_COND:   rsel = {15'h0000, cond_q};
                A_TERM:   rsel = {25'h0000000, term_q};
                A_STATUS: rsel = {13'h0000, status_q};
                A_MASK:   rsel = {13'h0000, mask_q};
                default:  rsel = 32'h0000_0000;
            endcase
        end
    end

    // Bus handshake and read capture
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ack_q <= req & ~ack_q;
            if (avs_read && !ack_q) begin
                rdata_q <= rsel;
            end
        end
    end

    // ************************************************************
    // Configuration registers
    // ************************************************************
    // Function codes: rewriting a code reassigns the terminal
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < N_TERM; i++) begin
                fcode_q[i] <= FCODE_RST[i];
            end
        end else if (wr_fire && hit_fc) begin
            fcode_q[fc_sel[2:0]] <= merge16(fcode_q[fc_sel[2:0]]);
        end
    end

    // Thresholds, limits and detection times
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < CFG_N; i++) begin
                cfg_q[i] <= CFG_RST;
            end
        end else if (wr_fire && hit_cfg) begin
            cfg_q[cfg_sel[3:0]] <= merge16(cfg_q[cfg_sel[3:0]]);
        end
    end

    // ************************************************************
    // Condition detection
    // ************************************************************
    wire [VAL_W-1:0] freq_diff = (output_freq >= set_freq) ? (output_freq - set_freq)
                                                           : (set_freq - output_freq);
    wire [VAL_W-1:0] lvl1_thr  = reverse_dir ? cfg_q[K_LVL1R] : cfg_q[K_LVL1];
    wire             cur_over  = output_current > cfg_q[K_CURTHR];
    wire             pwr_under = monitored_power < cfg_q[K_LOWTHR];

    wire running_ind           = drive_running && (output_freq >= cfg_q[K_START]);
    wire at_set_speed          = freq_diff <= cfg_q[K_BAND];
    wire power_loss_or_undervoltage = supply_interrupt | undervoltage;
    wire freq_level_one        = output_freq >= lvl1_thr;
    wire freq_level_two        = output_freq >= cfg_q[K_LVL2];
    wire freq_level_three      = output_freq >= cfg_q[K_LVL3];
    wire regen_brake_prealarm  = regen_duty_pct >= PREALARM_PCT;
    wire thermal_prealarm      = (thermal_inv_pct >= PREALARM_PCT) ||
                                 (thermal_mot_pct >= PREALARM_PCT);
    wire panel_operation_mode  = operation_mode == MODE_PANEL;
    wire ready_to_start        = rdy_done_q && (start_permitted || drive_running);
    wire current_over_threshold = cur_over && (cur_cnt_q > cfg_q[K_CURTIME]);
    wire low_current_detect    = pwr_under && (low_cnt_q > cfg_q[K_LOWTIME]);
    wire pid_below_limit       = pid_feedback < cfg_q[K_PIDLO];
    wire pid_above_limit       = pid_feedback > cfg_q[K_PIDHI];

    // Gather conditions into their code slots; slot 9 stays low
    always_comb begin
        cond_d           = '0;
        cond_d[C_RUN]    = running_ind;
        cond_d[C_SPEED]  = at_set_speed;
        cond_d[C_PLOSS]  = power_loss_or_undervoltage;
        cond_d[C_STALL]  = stall_prevention_active;
        cond_d[C_FL1]    = freq_level_one;
        cond_d[C_FL2]    = freq_level_two;
        cond_d[C_FL3]    = freq_level_three;
        cond_d[C_RBP]    = regen_brake_prealarm;
        cond_d[C_THP]    = thermal_prealarm;
        cond_d[C_PANEL]  = panel_operation_mode;
        cond_d[C_READY]  = ready_to_start;
        cond_d[C_CUR]    = current_over_threshold;
        cond_d[C_LOW]    = low_current_detect;
        cond_d[C_PIDLO]  = pid_below_limit;
        cond_d[C_PIDHI]  = pid_above_limit;
        cond_d[C_PIDFWD] = pid_forward_out;
    end

    // Continuous-time counters; any break in the condition restarts them
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cur_cnt_q <= '0;
            low_cnt_q <= '0;
        end else begin
            if (!cur_over) begin
                cur_cnt_q <= '0;
            end else if (cur_cnt_q != '1) begin
                cur_cnt_q <= cur_cnt_q + 1'b1;
            end
            if (!pwr_under) begin
                low_cnt_q <= '0;
            end else if (low_cnt_q != '1) begin
                low_cnt_q <= low_cnt_q + 1'b1;
            end
        end
    end

    // Power-up and reset processing delay before ready may show
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdy_cnt_q  <= 16'h0000;
            rdy_done_q <= 1'b0;
        end else if (!rdy_done_q) begin
            rdy_cnt_q  <= rdy_cnt_q + 16'h0001;
            rdy_done_q <= (rdy_cnt_q == 16'(READY_CYC - 1));
        end
    end

    // ************************************************************
    // Per-terminal code decode
    // ************************************************************
    genvar g;
    generate
        for (g = 0; g < N_TERM; g++) begin : g_term
            wire [CODE_W-1:0] code   = fcode_q[g];
            wire              is_pos = code <= POS_MAX;
            wire              is_neg = (code >= NEG_BASE) && (code <= NEG_MAX);
            wire [CODE_W-1:0] slot   = is_neg ? (code - NEG_BASE) : code;
            wire              known  = (is_pos || is_neg) && (slot < CODE_W'(COND_N))
                                       && COND_VALID[slot[4:0]];
            // Unknown codes stay off; negative codes invert the level
            assign term_d[g] = known & (cond_q[slot[4:0]] ^ is_neg);
        end
    endgenerate

    // Condition, terminal and trip registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cond_q     <= '0;
            term_q     <= '0;
            trip_inv_q <= 1'b0;
            trip_mot_q <= 1'b0;
        end else begin
            cond_q     <= cond_d;
            term_q     <= term_d;
            trip_inv_q <= thermal_inv_pct >= TRIP_PCT;
            trip_mot_q <= thermal_mot_pct >= TRIP_PCT;
        end
    end

    assign terminal_out          = term_q;
    assign thermal_trip_inverter = trip_inv_q;
    assign thermal_trip_motor    = trip_mot_q;

    // ************************************************************
    // Interrupt status and mask
    // ************************************************************
    wire [EVT_N-1:0] evt_now  = {trip_mot_q, trip_inv_q, cond_q};
    wire [EVT_N-1:0] evt_next = {thermal_mot_pct >= TRIP_PCT, thermal_inv_pct >= TRIP_PCT,
                                 cond_d};
    wire [EVT_N-1:0] evt_rise = evt_next & ~evt_now;       // Rising edges only

    // Sticky bits; a new event wins over a clear in the same cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            status_q <= '0;
            mask_q   <= MASK_RST;
        end else begin
            status_q <= (status_q & ~w1c) | evt_rise;
            if (wr_mask) begin
                mask_q <= (mask_q & ~be_mask[EVT_N-1:0]) |
                          (avs_writedata[EVT_N-1:0] & be_mask[EVT_N-1:0]);
            end
        end
    end

    assign irq = |(status_q & mask_q);

endmodule

// file: dso_selector_props.sv
// Checker of bus handshake, trip and terminal timing for the status output selector
`timescale 1ns/1ps
module dso_selector_props
    import dso_pkg::*;
(
    input wire logic              clk,
    input wire logic              rst,
    input wire logic [7:0]        avs_address,
    input wire logic              avs_read,
    input wire logic              avs_write,
    input wire logic [31:0]       avs_writedata,
    input wire logic [3:0]        avs_byteenable,
    input wire logic              avs_waitrequest,
    input wire logic              irq,
    input wire logic              supply_interrupt,
    input wire logic              undervoltage,
    input wire logic              stall_prevention_active,
    input wire logic [PCT_W-1:0]  thermal_inv_pct,
    input wire logic [PCT_W-1:0]  thermal_mot_pct,
    input wire logic              pid_forward_out,
    input wire logic [N_TERM-1:0] terminal_out,
    input wire logic              thermal_trip_inverter,
    input wire logic              thermal_trip_motor
);
    // ****************************************
    // Shadow of the terminal 0 function code
    // ****************************************
    logic [CODE_W-1:0] code0_q;   // Last full write to code register 0
    logic [CODE_W-1:0] base0;     // Code with polarity offset removed
    logic              undef0;    // Code names no condition
    // Follow accepted full-word writes to address 0
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            code0_q <= 16'h0000;
        end else if (avs_write && !avs_waitrequest && avs_address[7:2] == 6'h00 && avs_byteenable == 4'hf) begin
            code0_q <= avs_writedata[CODE_W-1:0];
        end
    end
    assign base0  = (code0_q >= NEG_BASE) ? code0_q - NEG_BASE : code0_q;
    assign undef0 = (code0_q > NEG_MAX) || (base0 == 16'h0009) || (base0 > 16'h0010);

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_wait_first: assert property ((avs_read || avs_write) && !$past(avs_read || avs_write) |-> avs_waitrequest)
        else $error("first request cycle not stalled");
    a_wait_single: assert property (avs_waitrequest |=> !avs_waitrequest)
        else $error("more than one wait state");
    a_trip_inv: assert property (thermal_inv_pct >= TRIP_PCT |=> thermal_trip_inverter)
        else $error("inverter trip missing at full accumulator");
    a_trip_clear: assert property ((thermal_inv_pct < TRIP_PCT)[*2] |-> !thermal_trip_inverter)
        else $error("inverter trip below full accumulator");
    a_trip_motor: assert property (thermal_mot_pct >= TRIP_PCT |=> thermal_trip_motor)
        else $error("motor trip missing at full accumulator");
    a_undef_quiet: assert property (undef0[*2] |-> !terminal_out[0])
        else $error("undefined code drives terminal");
    a_stall_pos: assert property ((code0_q == 16'h0003)[*3] |->
        terminal_out[0] == $past(stall_prevention_active, 2))
        else $error("stall indication wrong in positive logic");
    a_stall_neg: assert property ((code0_q == 16'h0067)[*3] |->
        terminal_out[0] != $past(stall_prevention_active, 2))
        else $error("stall indication wrong in negative logic");
    a_ploss_pos: assert property ((code0_q == 16'h0002)[*3] |->
        terminal_out[0] == $past(supply_interrupt || undervoltage, 2))
        else $error("power loss indication wrong");
    a_fwd_pos: assert property ((code0_q == 16'h0010)[*3] |-> terminal_out[0] == $past(pid_forward_out, 2))
        else $error("forward flag indication wrong");
    c_irq: cover property ($rose(irq));
    c_neg: cover property (code0_q == 16'h0067 && !terminal_out[0]);
    c_trip: cover property ($rose(thermal_trip_inverter));
endmodule
bind dso_selector dso_selector_props u_dso_selector_props (.clk, .rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_waitrequest, .irq, .supply_interrupt, .undervoltage,
    .stall_prevention_active, .thermal_inv_pct, .thermal_mot_pct, .pid_forward_out, .terminal_out,
    .thermal_trip_inverter, .thermal_trip_motor);

// file: dso_ctl_model.sv
// Model of the control equipment that watches the level of terminal 0
`timescale 1ns/1ps
module dso_ctl_model
    import dso_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic [N_TERM-1:0] terminal_out,
    output logic      [7:0]        rise_cnt
);
    logic last_q;   // Level of terminal 0 at the previous edge
    // Count rising edges seen on terminal 0
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            last_q   <= 1'h0;
            rise_cnt <= 8'h00;
        end else begin
            last_q   <= terminal_out[0];
            rise_cnt <= rise_cnt + {7'h00, terminal_out[0] & !last_q};
        end
    end
endmodule

// file: dso_selector_tb.sv
// Self-checking testbench of the drive status output selector
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin error_cnt++; \
    $display("[ERR] %s exp %0h got %0h", nm, exp, got); end end
module dso_selector_tb
    import dso_pkg::*;
;
    // ****************************************
    // Stimulus, start values make most conditions true
    // ****************************************
    logic              clk = 1'h0, rst = 1'h1, rd_q = 1'h0, wr_q = 1'h0;
    logic [7:0]        adr = 8'h00, rises;
    logic [31:0]       wdat = 32'h0, rdat, rd;
    logic              wait_rq, irq, trip_i, trip_m;
    logic              run = 1'h1, rev = 1'h0, sup = 1'h1, uv = 1'h0, stall = 1'h1, fwd = 1'h1, permit = 1'h1;
    logic [VAL_W-1:0]  ofreq = 16'h0064, sfreq = 16'h0064, cur = 16'h0005, pwr = 16'h0014, fb = 16'h0005;
    logic [PCT_W-1:0]  regen = 7'h55, thi = 7'h55, thm = 7'h55;
    logic [1:0]        mode = 2'h1;
    logic [N_TERM-1:0] term;
    int                error_cnt = 0, total_checks = 0;

    dso_selector u_dso_selector (.clk(clk), .rst(rst), .avs_address(adr), .avs_read(rd_q), .avs_write(wr_q),
        .avs_writedata(wdat), .avs_byteenable(4'hf), .avs_readdata(rdat), .avs_waitrequest(wait_rq), .irq(irq),
        .drive_running(run), .output_freq(ofreq), .set_freq(sfreq), .reverse_dir(rev), .supply_interrupt(sup),
        .undervoltage(uv), .stall_prevention_active(stall), .regen_duty_pct(regen), .thermal_inv_pct(thi),
        .thermal_mot_pct(thm), .operation_mode(mode), .start_permitted(permit), .output_current(cur),
        .monitored_power(pwr), .pid_feedback(fb), .pid_forward_out(fwd), .terminal_out(term),
        .thermal_trip_inverter(trip_i), .thermal_trip_motor(trip_m));
    dso_ctl_model u_dso_ctl_model (.clk(clk), .rst(rst), .terminal_out(term), .rise_cnt(rises));

    // Clock of 100 ns period
    initial begin
        forever #50 clk = ~clk;
    end

    // One Avalon transfer, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        adr <= a;
        wdat <= d;
        wr_q <= wr;
        rd_q <= !wr;
        do begin
            @(posedge clk);
        end while (wait_rq !== 1'h0);
        rd = rdat;
        wr_q <= 1'h0;
        rd_q <= 1'h0;
    endtask

    // Give terminal 0 a code and compare its level
    task automatic chk_term(input logic [15:0] code, input logic e);
        bus(1'h1, 8'h00, {16'h0000, code});
        repeat (3) @(posedge clk);
        `CHK("term0", e, term[0])
    endtask

    // Reset values of codes, an unmapped read and the default terminal set
    task automatic t_reset();
        logic [15:0] rc[7] = '{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0004, 16'h0063, 16'h270f};
        for (int i = 0; i < 7; i++) begin
            bus(1'h0, 8'(4 * i), 32'h0);
            `CHK("code", rc[i], rd[15:0])
        end
        bus(1'h0, 8'h80, 32'h0);
        `CHK("unmapped", 32'h0, rd)
        `CHK("terms", 7'h1f, term)
    endtask

    // Every code in both polarities, then codes outside the table
    task automatic t_all();
        logic e;
        repeat (100) @(posedge clk);
        for (int c = 0; c < 17; c++) begin
            e = (c != 9) && (c != 13) && (c != 14);
            chk_term(16'(c), e);
            chk_term(16'(c + 100), (c == 9) ? 1'h0 : !e);
        end
        chk_term(16'h00c8, 1'h0);
        chk_term(16'h270f, 1'h0);
    endtask

    // Threshold edges of levels, prealarms, trips and power loss
    task automatic t_lvl();
        bus(1'h1, 8'h24, 32'h64);
        bus(1'h1, 8'h28, 32'hc8);
        chk_term(16'h0004, 1'h1);
        ofreq <= 16'h0063;
        chk_term(16'h0004, 1'h0);
        ofreq <= 16'h0064;
        rev <= 1'h1;
        chk_term(16'h0004, 1'h0);
        bus(1'h1, 8'h2c, 32'h65);
        chk_term(16'h0005, 1'h0);
        chk_term(16'h0006, 1'h1);
        sfreq <= 16'h0066;
        chk_term(16'h0001, 1'h0);
        bus(1'h1, 8'h34, 32'h2);
        chk_term(16'h0001, 1'h1);
        bus(1'h1, 8'h20, 32'h65);
        chk_term(16'h0000, 1'h0);
        regen <= 7'h54;
        thi <= 7'h54;
        thm <= 7'h54;
        chk_term(16'h0007, 1'h0);
        chk_term(16'h0008, 1'h0);
        thm <= 7'h55;
        thi <= 7'h64;
        chk_term(16'h0008, 1'h1);
        `CHK("trip_inv", 1'h1, trip_i)
        `CHK("trip_mot", 1'h0, trip_m)
        sup <= 1'h0;
        uv <= 1'h1;
        chk_term(16'h0002, 1'h1);
        uv <= 1'h0;
        mode <= 2'h2;
        stall <= 1'h0;
        chk_term(16'h0002, 1'h0);
        chk_term(16'h000a, 1'h0);
        chk_term(16'h0003, 1'h0);
    endtask

    // Detection times of current and power, PID limits
    task automatic t_tmr();
        bus(1'h1, 8'h38, 32'ha);
        bus(1'h1, 8'h3c, 32'h5);
        bus(1'h1, 8'h40, 32'ha);
        bus(1'h1, 8'h44, 32'h5);
        chk_term(16'h000c, 1'h0);
        cur <= 16'h0014;
        repeat (5) @(posedge clk);
        `CHK("cur_early", 1'h0, term[0])
        repeat (5) @(posedge clk);
        `CHK("cur_late", 1'h1, term[0])
        chk_term(16'h000d, 1'h0);
        pwr <= 16'h0005;
        repeat (5) @(posedge clk);
        `CHK("low_early", 1'h0, term[0])
        repeat (5) @(posedge clk);
        `CHK("low_late", 1'h1, term[0])
        bus(1'h1, 8'h48, 32'ha);
        bus(1'h1, 8'h4c, 32'h5);
        chk_term(16'h000e, 1'h1);
        chk_term(16'h000f, 1'h0);
        fb <= 16'h0006;
        fwd <= 1'h0;
        chk_term(16'h000f, 1'h1);
        chk_term(16'h0010, 1'h0);
    endtask

    // Ready only after power-up time, and only while startable or running
    task automatic t_ready();
        @(posedge clk);
        rst <= 1'h1;
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        chk_term(16'h000b, 1'h0);
        repeat (100) @(posedge clk);
        `CHK("ready", 1'h1, term[0])
        permit <= 1'h0;
        run <= 1'h0;
        chk_term(16'h000b, 1'h0);
    endtask

    // Sticky status, mask and write-one-to-clear of the interrupt
    task automatic t_irq();
        logic [7:0] r;
        chk_term(16'h0003, 1'h0);
        bus(1'h1, 8'h5c, 32'h8);
        bus(1'h1, 8'h58, 32'h7ffff);
        `CHK("irq_idle", 1'h0, irq)
        r = rises;
        stall <= 1'h1;
        repeat (3) @(posedge clk);
        `CHK("irq_set", 1'h1, irq)
        bus(1'h0, 8'h58, 32'h0);
        `CHK("rises", r + 8'h01, rises)
        `CHK("status", 1'h1, rd[3])
        bus(1'h1, 8'h58, 32'h8);
        @(posedge clk);
        `CHK("irq_clr", 1'h0, irq)
        bus(1'h1, 8'h5c, 32'h0);
        stall <= 1'h0;
        repeat (2) @(posedge clk);
        stall <= 1'h1;
        repeat (3) @(posedge clk);
        `CHK("irq_mask", 1'h0, irq)
        bus(1'h0, 8'h58, 32'h0);
        `CHK("sticky", 1'h1, rd[3])
    endtask

    // Print counts and verdict, then stop
    task automatic conclude();
        $display("Checks %0d, errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'h0;
        t_reset();
        t_all();
        t_lvl();
        t_tmr();
        t_ready();
        t_irq();
        conclude();
    end

    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        conclude();
    end
endmodule
